// ==== rtl/gidx_defines.svh ====
// offsets, field positions and reset values of the global interrupt index slice
// assumes byte-wide register addressing inside a 256-byte page
`ifndef GIDX_DEFINES_SVH
`define GIDX_DEFINES_SVH

`define GIDX_GLOBAL_SPAN      8'h10
`define GIDX_OFF_CONV_EN      8'h05
`define GIDX_OFF_EXT_INDEX    8'h06
`define GIDX_OFF_INT_INDEX    8'h0a
`define GIDX_OFF_DIR          8'h10
`define GIDX_DIR_PAGE         2'h0

`define GIDX_CONV_EN_RESET    8'h00
`define GIDX_INDEX_RESET      32'h0000_0000
`define GIDX_DIR_RESET        32'hffff_77ff

`define GIDX_BIT_SMALL_BUCK_A 0
`define GIDX_BIT_SMALL_BUCK_B 1
`define GIDX_BIT_LARGE_BUCK   2
`define GIDX_BIT_FIVE_V_BOOST 3
`define GIDX_BIT_BL_BOOST     4
`define GIDX_BIT_CLASS_D      7

`define GIDX_BIT_GPIO_FIRST   1
`define GIDX_BIT_SHORT_PRESS  12
`define GIDX_BIT_MID_PRESS    14
`define GIDX_BIT_BOTH         15
`define GIDX_BIT_WATCHDOG     16
`define GIDX_BIT_GP_TIMER     17
`define GIDX_BIT_ALARM_ONE    18
`define GIDX_BIT_ALARM_TWO    19
`define GIDX_BIT_REG_FAULT    20
`define GIDX_BIT_CONV_FAULT   21
`define GIDX_BIT_CHARGER      22
`define GIDX_BIT_AMP_FAULT    23
`define GIDX_BIT_PEN_DOWN     24
`define GIDX_BIT_TEMP_HIGH    25
`define GIDX_BIT_BATT_LOW     26
`define GIDX_BIT_SYS_LOW      27
`define GIDX_BIT_ADC_OTHER    28
`define GIDX_BIT_BATT_XLOW    29
`define GIDX_BIT_TEMP_XHIGH   30

`endif

// ==== rtl/gidx_pkg.sv ====
// types shared by the global interrupt index slice
// assumes nothing beyond a SystemVerilog compiler
package gidx_pkg;
  typedef logic [7:0]  gidx_byte_t;
  typedef logic [31:0] gidx_word_t;
  typedef logic [1:0]  gidx_page_t;
endpackage : gidx_pkg

// ==== rtl/gidx_route.sv ====
// steers each pending source to the host view, the controller view or both
// assumes direction word and pending word share one bit map
`include "gidx_defines.svh"
module gidx_route
  import gidx_pkg::*;
(
  gidx_src_if.router src
);
  logic both;
  assign both = src.dir[`GIDX_BIT_BOTH];

  for (genvar b = 0; b < 32; b++) begin : g_bit
    assign src.ext_view[b] = src.pending[b] & (~src.dir[b] | both);
    assign src.int_view[b] = src.pending[b] & ( src.dir[b] | both);
  end
endmodule : gidx_route

// ==== rtl/gidx_src_if.sv ====
// carrier between source mapper, direction router and the top
// assumes all members live on ref_clk
interface gidx_src_if;
  import gidx_pkg::*;
  gidx_word_t pending;
  gidx_word_t dir;
  gidx_word_t ext_view;
  gidx_word_t int_view;
  modport mapper (output pending);
  modport router (input pending, input dir, output ext_view, output int_view);
endinterface : gidx_src_if

// ==== rtl/gidx_src_map.sv ====
// places module status flags onto the 32-bit source word
// assumes flags come from logic on the same clock
`include "gidx_defines.svh"
module gidx_src_map
  import gidx_pkg::*;
#(
  parameter int GPIO_N = 10
) (
  input  wire logic [GPIO_N-1:0] gpio_flag,
  input  wire logic              short_press_event,
  input  wire logic              mid_press_event,
  input  wire logic              watchdog_timeout,
  input  wire logic              general_timer_timeout,
  input  wire logic              alarm_one_event,
  input  wire logic              alarm_two_event,
  input  wire logic [7:0]        regulator_fault,
  input  wire logic [3:0]        converter_fault,
  input  wire logic              charger_event,
  input  wire logic              amp_status_a_bit4,
  input  wire logic              amp_status_b_bit4,
  input  wire logic              pen_down,
  input  wire logic              die_temp_high,
  input  wire logic              batt_low,
  input  wire logic              sys_low,
  input  wire logic              adc_other,
  input  wire logic              batt_extreme_low,
  input  wire logic              die_temp_extreme,
  gidx_src_if.mapper             src
);
  if (GPIO_N != 10) begin : g_bad_gpio_n
    $error("gidx_src_map: only ten gpio sources fit the index");
  end

  gidx_word_t word;

  for (genvar g = 0; g < GPIO_N; g++) begin : g_gpio
    assign word[`GIDX_BIT_GPIO_FIRST + g] = gpio_flag[g];
  end

  assign word[0]                     = 1'b0;
  assign word[11]                    = 1'b0;
  assign word[`GIDX_BIT_SHORT_PRESS] = short_press_event;
  assign word[13]                    = 1'b0;
  assign word[`GIDX_BIT_MID_PRESS]   = mid_press_event;
  assign word[`GIDX_BIT_BOTH]        = 1'b0;
  assign word[`GIDX_BIT_WATCHDOG]    = watchdog_timeout;
  assign word[`GIDX_BIT_GP_TIMER]    = general_timer_timeout;
  assign word[`GIDX_BIT_ALARM_ONE]   = alarm_one_event;
  assign word[`GIDX_BIT_ALARM_TWO]   = alarm_two_event;
  assign word[`GIDX_BIT_REG_FAULT]   = |regulator_fault;
  assign word[`GIDX_BIT_CONV_FAULT]  = |converter_fault;
  assign word[`GIDX_BIT_CHARGER]     = charger_event;
  assign word[`GIDX_BIT_AMP_FAULT]   = amp_status_a_bit4 & amp_status_b_bit4;
  assign word[`GIDX_BIT_PEN_DOWN]    = pen_down;
  assign word[`GIDX_BIT_TEMP_HIGH]   = die_temp_high;
  assign word[`GIDX_BIT_BATT_LOW]    = batt_low;
  assign word[`GIDX_BIT_SYS_LOW]     = sys_low;
  assign word[`GIDX_BIT_ADC_OTHER]   = adc_other;
  assign word[`GIDX_BIT_BATT_XLOW]   = batt_extreme_low;
  assign word[`GIDX_BIT_TEMP_XHIGH]  = die_temp_extreme;
  assign word[31]                    = 1'b0;

  assign src.pending = word;
endmodule : gidx_src_map

// ==== rtl/gidx_top.sv ====
// global register slice: converter enables, interrupt direction, two index views
// assumes byte register port on ref_clk, flags from same-clock module logic
`include "gidx_defines.svh"
module gidx_top
  import gidx_pkg::*;
#(
  parameter int GPIO_N = 10
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [1:0]        page,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic [GPIO_N-1:0] gpio_flag,
  input  wire logic              short_press_event,
  input  wire logic              mid_press_event,
  input  wire logic              watchdog_timeout,
  input  wire logic              general_timer_timeout,
  input  wire logic              alarm_one_event,
  input  wire logic              alarm_two_event,
  input  wire logic [7:0]        regulator_fault,
  input  wire logic [3:0]        converter_fault,
  input  wire logic              charger_event,
  input  wire logic              amp_status_a_bit4,
  input  wire logic              amp_status_b_bit4,
  input  wire logic              pen_down,
  input  wire logic              die_temp_high,
  input  wire logic              batt_low,
  input  wire logic              sys_low,
  input  wire logic              adc_other,
  input  wire logic              batt_extreme_low,
  input  wire logic              die_temp_extreme,
  output logic                   small_buck_a_on,
  output logic                   small_buck_b_on,
  output logic                   large_buck_on,
  output logic                   five_volt_boost_on,
  output logic                   backlight_boost_on,
  output logic                   class_d_on,
  output logic      [31:0]       host_irq_view,
  output logic      [31:0]       cpu_irq_view,
  output logic                   host_irq,
  output logic                   cpu_irq
);
  if (GPIO_N != 10) begin : g_bad_gpio_n
    $error("gidx_top: index map holds exactly ten gpio sources");
  end

  gidx_src_if src ();

  gidx_byte_t conv_en;
  gidx_word_t dir;

  gidx_src_map #(
    .GPIO_N (GPIO_N)
  ) u_map (
    .gpio_flag             (gpio_flag),
    .short_press_event     (short_press_event),
    .mid_press_event       (mid_press_event),
    .watchdog_timeout      (watchdog_timeout),
    .general_timer_timeout (general_timer_timeout),
    .alarm_one_event       (alarm_one_event),
    .alarm_two_event       (alarm_two_event),
    .regulator_fault       (regulator_fault),
    .converter_fault       (converter_fault),
    .charger_event         (charger_event),
    .amp_status_a_bit4     (amp_status_a_bit4),
    .amp_status_b_bit4     (amp_status_b_bit4),
    .pen_down              (pen_down),
    .die_temp_high         (die_temp_high),
    .batt_low              (batt_low),
    .sys_low               (sys_low),
    .adc_other             (adc_other),
    .batt_extreme_low      (batt_extreme_low),
    .die_temp_extreme      (die_temp_extreme),
    .src                   (src)
  );

  gidx_route u_route (
    .src (src)
  );

  assign src.dir = dir;

  // address decode
  logic       is_global;
  logic       hit_conv;
  logic       hit_ext;
  logic       hit_int;
  logic       hit_dir;
  logic [1:0] lane;

  assign is_global = reg_addr < `GIDX_GLOBAL_SPAN;
  assign hit_conv  = is_global && reg_addr == `GIDX_OFF_CONV_EN;
  assign hit_ext   = is_global && reg_addr >= `GIDX_OFF_EXT_INDEX && reg_addr < `GIDX_OFF_INT_INDEX;
  assign hit_int   = is_global && reg_addr >= `GIDX_OFF_INT_INDEX && reg_addr < `GIDX_GLOBAL_SPAN;
  assign hit_dir   = page == `GIDX_DIR_PAGE && reg_addr >= `GIDX_OFF_DIR
                     && reg_addr < 8'(`GIDX_OFF_DIR + 8'h04);
  assign lane      = hit_ext ? 2'(reg_addr - `GIDX_OFF_EXT_INDEX)
                   : hit_int ? 2'(reg_addr - `GIDX_OFF_INT_INDEX)
                   : 2'(reg_addr - `GIDX_OFF_DIR);

  // converter enables
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_en <= `GIDX_CONV_EN_RESET;
    end else if (reg_wr && hit_conv) begin
      conv_en <= reg_wdata;
    end
  end

  assign small_buck_a_on    = conv_en[`GIDX_BIT_SMALL_BUCK_A];
  assign small_buck_b_on    = conv_en[`GIDX_BIT_SMALL_BUCK_B];
  assign large_buck_on      = conv_en[`GIDX_BIT_LARGE_BUCK];
  assign five_volt_boost_on = conv_en[`GIDX_BIT_FIVE_V_BOOST];
  assign backlight_boost_on = conv_en[`GIDX_BIT_BL_BOOST];
  assign class_d_on         = conv_en[`GIDX_BIT_CLASS_D];

  // direction word, one byte lane per write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dir <= `GIDX_DIR_RESET;
    end else if (reg_wr && hit_dir) begin
      dir[lane*8 +: 8] <= reg_wdata;
    end
  end

  // registered copies of the routed views
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_irq_view <= `GIDX_INDEX_RESET;
      cpu_irq_view  <= `GIDX_INDEX_RESET;
    end else begin
      host_irq_view <= src.ext_view;
      cpu_irq_view  <= src.int_view;
    end
  end

  assign host_irq = |host_irq_view;
  assign cpu_irq  = |cpu_irq_view;

  // read mux: index lanes are live, writes to them fall through
  always_comb begin
    reg_rdata = 8'h00;
    if (hit_conv) begin
      reg_rdata = conv_en;
    end else if (hit_ext) begin
      reg_rdata = src.ext_view[lane*8 +: 8];
    end else if (hit_int) begin
      reg_rdata = src.int_view[lane*8 +: 8];
    end else if (hit_dir) begin
      reg_rdata = dir[lane*8 +: 8];
    end
  end
endmodule : gidx_top

// ==== sim/gidx_flag_src.sv ====
// flag sources of the functional modules
// assumes the bench loads a new flag set with ld
module gidx_flag_src (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ld,
  input  wire logic [37:0] next_flags,
  output logic      [37:0] flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // flags live and clear here, not in the index
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags <= '0;
    end else if (ld) begin
      flags <= next_flags;
    end
  end
endmodule : gidx_flag_src

// ==== sim/gidx_top_asserts.sv ====
// checker for the global index slice
// assumes bind onto gidx_top, one clock
module gidx_top_asserts #(
  parameter int GPIO_N = 10
) (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic [7:0]        reg_wdata,
  input wire logic [GPIO_N-1:0] gpio_flag,
  input wire logic [7:0]        regulator_fault,
  input wire logic [3:0]        converter_fault,
  input wire logic              amp_status_a_bit4,
  input wire logic              amp_status_b_bit4,
  input wire logic              small_buck_a_on,
  input wire logic              small_buck_b_on,
  input wire logic              large_buck_on,
  input wire logic              five_volt_boost_on,
  input wire logic              backlight_boost_on,
  input wire logic              class_d_on,
  input wire logic [31:0]       host_irq_view,
  input wire logic [31:0]       cpu_irq_view
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] seen;
  logic [5:0]  en;
  assign seen = host_irq_view | cpu_irq_view;
  assign en = {class_d_on, backlight_boost_on, five_volt_boost_on, large_buck_on, small_buck_b_on, small_buck_a_on};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  conv_en_a: assert property (reg_wr && reg_addr == 8'h05 |=> en == {$past(reg_wdata[7]), $past(reg_wdata[4:0])})
    else $error("enable write lost");
  idx_wr_ign_a: assert property (reg_wr && reg_addr inside {[8'h06:8'h0d]} |=> $stable(en))
    else $error("index write changed enables");
  gpio_map_a: assert property (1'b1 |=> seen[GPIO_N:1] == $past(gpio_flag))
    else $error("gpio bits misplaced");
  rsv_zero_a: assert property (!(seen[0] || seen[11] || seen[13] || seen[15] || seen[31]))
    else $error("reserved index bit set");
  reg_fault_a: assert property (1'b1 |=> seen[20] == |$past(regulator_fault))
    else $error("regulator fault bit wrong");
  conv_fault_a: assert property (1'b1 |=> seen[21] == |$past(converter_fault))
    else $error("converter fault bit wrong");
  amp_fault_a: assert property (1'b1 |=> seen[23] == ($past(amp_status_a_bit4) && $past(amp_status_b_bit4)))
    else $error("amplifier fault bit wrong");
  both_dir_a: assert property ((host_irq_view & cpu_irq_view) != 32'h0 |-> host_irq_view == cpu_irq_view)
    else $error("shared source not sent to both");
endmodule : gidx_top_asserts

bind gidx_top gidx_top_asserts #(.GPIO_N(GPIO_N)) i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .gpio_flag(gpio_flag), .regulator_fault(regulator_fault),
  .converter_fault(converter_fault), .amp_status_a_bit4(amp_status_a_bit4), .amp_status_b_bit4(amp_status_b_bit4),
  .small_buck_a_on(small_buck_a_on), .small_buck_b_on(small_buck_b_on), .large_buck_on(large_buck_on),
  .five_volt_boost_on(five_volt_boost_on), .backlight_boost_on(backlight_boost_on), .class_d_on(class_d_on),
  .host_irq_view(host_irq_view), .cpu_irq_view(cpu_irq_view));

// ==== sim/gidx_top_test.sv ====
// bench for the global index slice against a behavioural model
// assumes gidx_top, its checker and the flag source model
module gidx_top_test
  import gidx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_b = 0, ld = 0, reg_wr = 0, hi, ci;
  gidx_page_t page = 0;
  gidx_byte_t reg_addr = 0, reg_wdata = 0, rd, ev = 0;
  logic [7:0] reg_rdata;
  logic [37:0] nf = 0, v;
  wire [37:0] f;
  wire [5:0] en;
  gidx_word_t hv, cv, d, p, e, seed = 32'h6cc1;
  int failures = 0, cmp_count = 0;
  always #4 ref_clk = ~ref_clk;
  gidx_flag_src i_src (.ref_clk(ref_clk), .rst_b(rst_b), .ld(ld), .next_flags(nf), .flags(f));
  gidx_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .page(page), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gpio_flag(f[9:0]), .short_press_event(f[10]),
    .mid_press_event(f[11]), .watchdog_timeout(f[12]), .general_timer_timeout(f[13]), .alarm_one_event(f[14]),
    .alarm_two_event(f[15]), .regulator_fault(f[23:16]), .converter_fault(f[27:24]), .charger_event(f[28]),
    .amp_status_a_bit4(f[29]), .amp_status_b_bit4(f[30]), .pen_down(f[31]), .die_temp_high(f[32]),
    .batt_low(f[33]), .sys_low(f[34]), .adc_other(f[35]), .batt_extreme_low(f[36]), .die_temp_extreme(f[37]),
    .small_buck_a_on(en[0]), .small_buck_b_on(en[1]), .large_buck_on(en[2]), .five_volt_boost_on(en[3]),
    .backlight_boost_on(en[4]), .class_d_on(en[5]), .host_irq_view(hv), .cpu_irq_view(cv), .host_irq(hi),
    .cpu_irq(ci));
  function automatic gidx_word_t lfsr(input gidx_word_t x);
    return x[31] ? {x[30:0], 1'b0} ^ 32'h04c1_1db7 : {x[30:0], 1'b0};
  endfunction : lfsr
  function automatic gidx_word_t pend(input logic [37:0] s);
    gidx_word_t r;
    r = '0;
    r[10:1] = s[9:0];
    r[12] = s[10];
    r[14] = s[11];
    r[19:16] = s[15:12];
    r[20] = |s[23:16];
    r[21] = |s[27:24];
    r[22] = s[28];
    r[23] = s[29] & s[30];
    r[30:24] = s[37:31];
    return r;
  endfunction : pend
  task automatic chk(input gidx_word_t g, input gidx_word_t x);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input gidx_byte_t a, input gidx_byte_t b, input gidx_page_t pg);
    @(posedge ref_clk);
    page <= pg;
    reg_addr <= a;
    reg_wdata <= b;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdb(input gidx_byte_t a, input gidx_page_t pg);
    @(posedge ref_clk);
    page <= pg;
    reg_addr <= a;
    #1 rd = reg_rdata;
  endtask : rdb
  task automatic rdw(input gidx_byte_t a, input gidx_page_t pg, input gidx_word_t x);
    for (int i = 0; i < 4; i++) begin
      rdb(a + 8'(i), pg);
      chk({24'h0, rd}, {24'h0, x[8*i+:8]});
    end
  endtask : rdw
  task automatic summarize;
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    rdw(8'h06, 2'h0, 32'h0);
    rdw(8'h0a, 2'h0, 32'h0);
    rdw(8'h10, 2'h0, 32'hffff_77ff);
    chk({26'h0, en} | hv | cv | {30'h0, hi, ci}, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      ev = seed[7:0] ^ 8'(1 << i);
      wr(8'h05, ev, seed[9:8]);
      rdb(8'h05, seed[11:10]);
      chk({24'h0, rd}, {24'h0, ev});
    end
    chk({26'h0, en}, {26'h0, ev[7], ev[4:0]});
    $display("enable test done");
    for (int i = 6; i < 14; i++) wr(8'(i), 8'hff, 2'(i));
    rdw(8'h06, 2'h1, 32'h0);
    rdw(8'h0a, 2'h2, 32'h0);
    chk({26'h0, en}, {26'h0, ev[7], ev[4:0]});
    $display("index write test done");
    for (int n = 0; n < 40; n++) begin
      seed = lfsr(seed);
      d = seed;
      for (int i = 0; i < 4; i++) wr(8'h10 + 8'(i), d[8*i+:8], 2'h0);
      seed = lfsr(seed);
      v = {seed[5:0], seed};
      seed = lfsr(seed);
      v = v & {seed[5:0], seed};
      @(posedge ref_clk);
      nf <= v;
      ld <= 1'b1;
      @(posedge ref_clk);
      ld <= 1'b0;
      p = pend(v);
      e = p & (~d | {32{d[15]}});
      rdw(8'h06, seed[9:8], e);
      rdw(8'h0a, seed[11:10], p & (d | {32{d[15]}}));
      @(posedge ref_clk);
      #1 chk(hv, e);
      chk(cv, p & (d | {32{d[15]}}));
      chk({31'h0, hi}, {31'h0, |e});
      chk({31'h0, ci}, {31'h0, |(p & (d | {32{d[15]}}))});
    end
    $display("source test done");
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    chk({26'h0, en} | hv | cv | {30'h0, hi, ci}, 32'h0);
    wr(8'h10, 8'h00, 2'h3);
    rdw(8'h10, 2'h1, 32'h0);
    rdw(8'h10, 2'h0, 32'hffff_77ff);
    $display("mid-run reset test done");
    summarize();
  end
  initial begin
    #40000;
    failures++;
    summarize();
  end
endmodule : gidx_top_test
